// file: bhc_regs.vh
// Constants for the bridge header command block: offsets, fields, codes.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BHC_REGS_VH
`define BHC_REGS_VH

// Dword offsets in configuration space (byte addresses)
`define BHC_OFF_ID          12'h000
`define BHC_OFF_CMD         12'h004

// Identification codes, arbitrary values
`define BHC_VENDOR_CODE     16'h5a5a
`define BHC_PART_CODE       16'h0c01

// Command register fields
`define BHC_CMD_IO_EN       0
`define BHC_CMD_MEM_EN      1
`define BHC_CMD_FWD_EN      2
`define BHC_CMD_POISON_EN   6
`define BHC_CMD_FATAL_EN    8
`define BHC_CMD_IRQ_MASK    10
`define BHC_CMD_WR_MASK     16'h0547
`define BHC_CMD_RESET       16'h0000

// Status register fields
`define BHC_STS_POISON      8
`define BHC_STS_ERR_SENT    14
`define BHC_STS_RESET       16'h0000

// Primary request spaces
`define BHC_SPACE_IO        2'h0
`define BHC_SPACE_MEM       2'h1

// Secondary request kinds
`define BHC_KIND_MEM        2'h0
`define BHC_KIND_IO         2'h1
`define BHC_KIND_OTHER      2'h2
`define BHC_KIND_CPL        2'h3

// Error message codes
`define BHC_MSG_COR         2'h0
`define BHC_MSG_NONFATAL    2'h1
`define BHC_MSG_FATAL       2'h3

// Window index in the decoder array
`define BHC_WIN_IO          0
`define BHC_WIN_MEM         1
`define BHC_WIN_PREF        2
`define BHC_WIN_COUNT       3

`endif

// file: bhc_window_hit.v
// Base and limit comparator for one address window of the bridge.
// Assumes low and high are inclusive bounds already expanded to full width.
`timescale 1ns/1ps

module bhc_window_hit #(
  parameter ADDR_W = 32
) (
  input  wire [ADDR_W-1:0] addr,
  input  wire [ADDR_W-1:0] win_low,
  input  wire [ADDR_W-1:0] win_high,
  output wire              hit
);

  // A window whose high is below its low is empty and never hits
  assign hit = (addr >= win_low) && (addr <= win_high);

endmodule

// file: bhc_cmd_regs.v
// Type 1 header start of one switch port: identification, command and
// the two status flags it drives, plus the gating of traffic by command.
// Assumes all inputs synchronous to core_clk; event inputs are one-cycle pulses.
// Functional notes
// R1 - Vendor code halfword at offset 0 is read-only and fixed.
// R2 - Part code halfword at offset 2 is read-only, writes ignored.
// R3 - I/O enable clear: primary I/O accesses in the I/O window not claimed.
// R4 - Memory enable clear: primary memory accesses in both memory windows not claimed.
// R5 - Forward enable clear: no memory or I/O requests issued for subordinates.
// R6 - Forward enable clear: subordinate non-posted requests answered Unsupported Request.
// R7 - Forward enable ignores completions and non-memory, non-I/O requests.
// R8 - Poison enable set: poisoned completion or write sets master poison flag.
// R9 - Poison enable clear: master poison flag never set.
// R10 - Own fatal, non-fatal errors reported if fatal enable or device control allows.
// R11 - Fatal enable gates forwarding of secondary fatal and non-fatal messages.
// R12 - Secondary correctable messages are always forwarded.
// R13 - Interrupt mask set deasserts own legacy interrupt and its resolved state.
// R14 - Interrupt mask leaves forwarded secondary legacy interrupts untouched.
// R15 - Command bits 3,4,5,7,9 and 15:11 read zero.
// R16 - Master poison flag in status bit 8, write one clears.
// R17 - Status bit 14 set on sent fatal/non-fatal message with enable; W1C.
// R18 - Writable command bits reset to zero.
`timescale 1ns/1ps
`include "bhc_regs.vh"

module bhc_cmd_regs #(
  parameter ADDR_W = 32
) (
  input  wire              core_clk,
  input  wire              reset,
  // Configuration access from the primary side
  input  wire              cfg_req,
  input  wire              cfg_wr,
  input  wire [11:0]       cfg_addr,
  input  wire [3:0]        cfg_be,
  input  wire [31:0]       cfg_wdata,
  output reg               cfg_ack,
  output reg  [31:0]       cfg_rdata,
  // Window bounds from the later header registers
  input  wire [ADDR_W-1:0] io_window_low,
  input  wire [ADDR_W-1:0] io_window_high,
  input  wire [ADDR_W-1:0] mem_window_low,
  input  wire [ADDR_W-1:0] mem_window_high,
  input  wire [ADDR_W-1:0] prefetch_window_low,
  input  wire [ADDR_W-1:0] prefetch_window_high,
  // Primary-side request decode
  input  wire              pri_req_valid,
  input  wire [1:0]        pri_req_space,
  input  wire [ADDR_W-1:0] pri_req_addr,
  output reg               pri_dec_valid,
  output reg               pri_claim,
  // Subordinate-side requests travelling upstream
  input  wire              sec_req_valid,
  input  wire [1:0]        sec_req_kind,
  input  wire              sec_req_nonposted,
  output reg               sec_fwd,
  output reg               sec_ur,
  // Poison events
  input  wire              poison_cpl_rx,
  input  wire              poison_wr_tx,
  // Own error detection and device control enables
  input  wire              err_detect_fatal,
  input  wire              err_detect_nonfatal,
  input  wire              device_control_fatal_en,
  input  wire              device_control_nonfatal_en,
  output reg               own_msg_valid,
  output reg  [1:0]        own_msg_code,
  // Error messages from the secondary interface
  input  wire              sec_msg_valid,
  input  wire [1:0]        sec_msg_code,
  output reg               fwd_msg_valid,
  output reg  [1:0]        fwd_msg_code,
  // Legacy interrupts
  input  wire              own_irq_req,
  input  wire              sec_irq_in,
  output reg               own_irq_out,
  output reg               fwd_irq_out,
  // Command and status views for the rest of the port
  output reg  [15:0]       command_out,
  output reg  [15:0]       status_out
);

  // Byte-enable merge, used for command writes and status clears
  function [15:0] be_mask16;
    input [1:0] be;
    begin
      be_mask16 = {{8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Fatal and non-fatal codes share gating and status reporting
  function is_err_msg;
    input [1:0] code;
    begin
      is_err_msg = (code != `BHC_MSG_COR);
    end
  endfunction

  reg  [15:0] bridge_command_reg;
  reg  [15:0] bridge_command_next;
  reg  [15:0] bridge_status_reg;
  reg  [15:0] bridge_status_next;
  reg  [31:0] rdata_next;
  reg         own_msg_next;
  reg  [1:0]  own_code_next;
  reg         fwd_msg_next;
  reg         fwd_next;
  reg         ur_next;

  wire [ADDR_W-1:0] win_low  [0:`BHC_WIN_COUNT-1];
  wire [ADDR_W-1:0] win_high [0:`BHC_WIN_COUNT-1];
  wire [`BHC_WIN_COUNT-1:0] win_hit;

  wire io_en     = bridge_command_reg[`BHC_CMD_IO_EN];
  wire mem_en    = bridge_command_reg[`BHC_CMD_MEM_EN];
  wire fwd_en    = bridge_command_reg[`BHC_CMD_FWD_EN];
  wire poison_en = bridge_command_reg[`BHC_CMD_POISON_EN];
  wire fatal_en  = bridge_command_reg[`BHC_CMD_FATAL_EN];
  wire irq_mask  = bridge_command_reg[`BHC_CMD_IRQ_MASK];

  wire wr_cmd = cfg_req && cfg_wr && (cfg_addr == `BHC_OFF_CMD);

  // Window bounds gathered so one generate loop builds a decoder per window
  assign win_low[`BHC_WIN_IO]    = io_window_low;
  assign win_high[`BHC_WIN_IO]   = io_window_high;
  assign win_low[`BHC_WIN_MEM]   = mem_window_low;
  assign win_high[`BHC_WIN_MEM]  = mem_window_high;
  assign win_low[`BHC_WIN_PREF]  = prefetch_window_low;
  assign win_high[`BHC_WIN_PREF] = prefetch_window_high;

  genvar gi;
  generate
    for (gi = 0; gi < `BHC_WIN_COUNT; gi = gi + 1) begin : g_win
      bhc_window_hit #(
        .ADDR_W   (ADDR_W)
      ) u_win (
        .addr     (pri_req_addr),
        .win_low  (win_low[gi]),
        .win_high (win_high[gi]),
        .hit      (win_hit[gi])
      );
    end
  endgenerate

  // Command write: only the five enable bits and the interrupt mask are writable, the rest stay zero
  always @* begin
    bridge_command_next = bridge_command_reg;
    if (wr_cmd) begin
      bridge_command_next = (bridge_command_reg & ~(be_mask16(cfg_be[1:0]) &
                            `BHC_CMD_WR_MASK)) | (cfg_wdata[15:0] &
                            be_mask16(cfg_be[1:0]) & `BHC_CMD_WR_MASK); // R15
    end
  end

  // Own error message: enable from command or device control
  always @* begin
    own_msg_next  = 1'b0;
    own_code_next = `BHC_MSG_NONFATAL;
    if (err_detect_fatal && (fatal_en || device_control_fatal_en)) begin // R10
      own_msg_next  = 1'b1;
      own_code_next = `BHC_MSG_FATAL;
    end else if (err_detect_nonfatal && (fatal_en || device_control_nonfatal_en)) begin // R10
      own_msg_next  = 1'b1;
      own_code_next = `BHC_MSG_NONFATAL;
    end
  end

  // Secondary messages: correctable always, others only with fatal enable
  always @* begin
    fwd_msg_next = 1'b0;
    if (sec_msg_valid) begin
      if (!is_err_msg(sec_msg_code)) begin
        fwd_msg_next = 1'b1; // R12
      end else begin
        fwd_msg_next = fatal_en; // R11
      end
    end
  end

  // Status flags: a new event beats a same-cycle write-one clear
  always @* begin
    bridge_status_next = bridge_status_reg;
    if (wr_cmd) begin
      bridge_status_next = bridge_status_reg & ~(cfg_wdata[31:16] &
                           be_mask16(cfg_be[3:2])); // R16 R17
    end
    if (poison_en && (poison_cpl_rx || poison_wr_tx)) begin
      bridge_status_next[`BHC_STS_POISON] = 1'b1; // R8 R9
    end
    if (fatal_en && (own_msg_next || (fwd_msg_next && is_err_msg(sec_msg_code)))) begin
      bridge_status_next[`BHC_STS_ERR_SENT] = 1'b1; // R17
    end
  end

  // Upstream request gating by the forward enable
  always @* begin
    fwd_next = 1'b0;
    ur_next  = 1'b0;
    if (sec_req_valid) begin
      if (sec_req_kind == `BHC_KIND_MEM || sec_req_kind == `BHC_KIND_IO) begin
        fwd_next = fwd_en; // R5
        ur_next  = ~fwd_en && sec_req_nonposted; // R6
      end else begin
        fwd_next = 1'b1; // R7
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    rdata_next = 32'h0000_0000;
    case (cfg_addr)
      `BHC_OFF_ID: begin
        rdata_next = {`BHC_PART_CODE, `BHC_VENDOR_CODE}; // R1 R2
      end
      `BHC_OFF_CMD: begin
        rdata_next = {bridge_status_reg, bridge_command_reg};
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Registers and configuration answer
  always @(posedge core_clk) begin
    if (reset) begin
      bridge_command_reg <= `BHC_CMD_RESET; // R18
      bridge_status_reg  <= `BHC_STS_RESET;
      cfg_ack            <= 1'b0;
      cfg_rdata          <= 32'h0000_0000;
    end else begin
      bridge_command_reg <= bridge_command_next;
      bridge_status_reg  <= bridge_status_next;
      cfg_ack            <= cfg_req;
      // Read data only updates on reads, so it holds between accesses
      if (cfg_req && !cfg_wr) begin
        cfg_rdata <= rdata_next;
      end
    end
  end

  // Primary decode and claim, one cycle after the request
  always @(posedge core_clk) begin
    if (reset) begin
      pri_dec_valid <= 1'b0;
      pri_claim     <= 1'b0;
    end else begin
      pri_dec_valid <= pri_req_valid;
      if (pri_req_space == `BHC_SPACE_IO) begin
        pri_claim <= pri_req_valid && io_en && win_hit[`BHC_WIN_IO]; // R3
      end else begin
        pri_claim <= pri_req_valid && mem_en &&
                     (win_hit[`BHC_WIN_MEM] || win_hit[`BHC_WIN_PREF]); // R4
      end
    end
  end

  // Traffic outputs, all registered
  always @(posedge core_clk) begin
    if (reset) begin
      sec_fwd       <= 1'b0;
      sec_ur        <= 1'b0;
      own_msg_valid <= 1'b0;
      own_msg_code  <= `BHC_MSG_COR;
      fwd_msg_valid <= 1'b0;
      fwd_msg_code  <= `BHC_MSG_COR;
      own_irq_out   <= 1'b0;
      fwd_irq_out   <= 1'b0;
      command_out   <= `BHC_CMD_RESET;
      status_out    <= `BHC_STS_RESET;
    end else begin
      sec_fwd       <= fwd_next;
      sec_ur        <= ur_next;
      own_msg_valid <= own_msg_next;
      own_msg_code  <= own_code_next;
      fwd_msg_valid <= fwd_msg_next;
      fwd_msg_code  <= sec_msg_code;
      own_irq_out   <= own_irq_req && !irq_mask; // R13
      fwd_irq_out   <= sec_irq_in; // R14
      command_out   <= bridge_command_next;
      status_out    <= bridge_status_next;
    end
  end

endmodule

// file: bhc_cmd_regs_assertions.sv
// Checker for the bridge header command block, bound to its top module.
// Assumes the ports of bhc_cmd_regs and the shared constants header.
`timescale 1ns/1ps
`include "bhc_regs.vh"
module bhc_cmd_chk (
  input wire        core_clk,
  input wire        reset,
  input wire        cfg_req,
  input wire        cfg_wr,
  input wire [11:0] cfg_addr,
  input wire        cfg_ack,
  input wire [31:0] cfg_rdata,
  input wire        pri_req_valid,
  input wire [1:0]  pri_req_space,
  input wire        pri_claim,
  input wire        sec_req_valid,
  input wire [1:0]  sec_req_kind,
  input wire        sec_req_nonposted,
  input wire        sec_fwd,
  input wire        sec_ur,
  input wire        sec_msg_valid,
  input wire [1:0]  sec_msg_code,
  input wire        fwd_msg_valid,
  input wire [1:0]  fwd_msg_code,
  input wire        sec_irq_in,
  input wire        own_irq_out,
  input wire        fwd_irq_out,
  input wire [15:0] command_out,
  input wire [15:0] status_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Each property except p_rsv ties an output to its cause one cycle earlier
  property p_id;
    cfg_req && !cfg_wr && cfg_addr == `BHC_OFF_ID
      |=> cfg_rdata == {`BHC_PART_CODE, `BHC_VENDOR_CODE};
  endproperty
  a_id: assert property (p_id) else $error("id read wrong");
  property p_rsv;
    (command_out & ~`BHC_CMD_WR_MASK) == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("fixed command bit set");
  property p_io;
    pri_req_valid && pri_req_space == `BHC_SPACE_IO && !command_out[0] |=> !pri_claim;
  endproperty
  a_io: assert property (p_io) else $error("io claimed while off");
  property p_mem;
    pri_req_valid && pri_req_space != `BHC_SPACE_IO && !command_out[1] |=> !pri_claim;
  endproperty
  a_mem: assert property (p_mem) else $error("mem claimed while off");
  property p_ur;
    sec_req_valid && sec_req_kind < `BHC_KIND_OTHER && !command_out[2]
      |=> !sec_fwd && sec_ur == $past(sec_req_nonposted);
  endproperty
  a_ur: assert property (p_ur) else $error("request passed while off");
  property p_oth;
    sec_req_valid && sec_req_kind >= `BHC_KIND_OTHER |=> sec_fwd && !sec_ur;
  endproperty
  a_oth: assert property (p_oth) else $error("other traffic held");
  property p_poi;
    $rose(status_out[8]) |-> $past(command_out[6]);
  endproperty
  a_poi: assert property (p_poi) else $error("poison flag while off");
  property p_cor;
    sec_msg_valid && sec_msg_code == `BHC_MSG_COR
      |=> fwd_msg_valid && fwd_msg_code == `BHC_MSG_COR;
  endproperty
  a_cor: assert property (p_cor) else $error("cor message lost");
  property p_fat;
    sec_msg_valid && sec_msg_code != `BHC_MSG_COR && !command_out[8] |=> !fwd_msg_valid;
  endproperty
  a_fat: assert property (p_fat) else $error("error message leaked");
  property p_irq;
    own_irq_out |-> !$past(command_out[10]);
  endproperty
  a_irq: assert property (p_irq) else $error("masked irq seen");
  property p_fwi;
    !$past(reset) |-> fwd_irq_out == $past(sec_irq_in);
  endproperty
  a_fwi: assert property (p_fwi) else $error("forwarded irq wrong");
  c_ur: cover property (sec_req_valid && !command_out[2] ##1 sec_ur);
  c_poi: cover property ($rose(status_out[8]));
  c_fat: cover property (fwd_msg_valid && fwd_msg_code == `BHC_MSG_FATAL);
endmodule
bind bhc_cmd_regs bhc_cmd_chk bhc_cmd_chk_i (.core_clk, .reset, .cfg_req, .cfg_wr,
  .cfg_addr, .cfg_ack, .cfg_rdata, .pri_req_valid, .pri_req_space, .pri_claim,
  .sec_req_valid, .sec_req_kind, .sec_req_nonposted, .sec_fwd, .sec_ur, .sec_msg_valid,
  .sec_msg_code, .fwd_msg_valid, .fwd_msg_code, .sec_irq_in, .own_irq_out,
  .fwd_irq_out, .command_out, .status_out);

// file: bhc_cfg_host.sv
// Root-side configuration master model for the command block bench.
// Assumes one caller at a time; each access takes whole clock cycles.
`timescale 1ns/1ps
module bhc_cfg_host (
  input  wire        core_clk,
  output reg         cfg_req,
  output reg         cfg_wr,
  output reg  [11:0] cfg_addr,
  output reg  [3:0]  cfg_be,
  output reg  [31:0] cfg_wdata,
  input  wire        cfg_ack,
  input  wire [31:0] cfg_rdata
);
  // Quiet bus at time zero
  initial begin
    {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {50{1'b0}};
  end
  // Strobe for one edge, hold qualifiers until ack, then show inverted junk
  task access(input w, input [11:0] a, input [3:0] b, input [31:0] d,
              output [31:0] q, output ok);
    integer n;
    begin
      @(posedge core_clk);
      #1 {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, w, a, b, d};
      @(posedge core_clk);
      #1 cfg_req = 1'b0;
      ok = 1'b0;
      for (n = 0; n < 8 && !ok; n = n + 1) begin
        @(posedge core_clk);
        ok = (cfg_ack === 1'b1);
        q = cfg_rdata;
      end
      #1 {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = ~{w, a, b, d};
    end
  endtask
endmodule

// file: tb_bhc_cmd_regs.sv
// Self-checking bench for the bridge header command block.
// Assumes the design, its bound checker and the host model are compiled.
`timescale 1ns/1ps
`include "bhc_regs.vh"
module tb_bhc_cmd_regs;
  reg         core_clk = 1'b0;
  reg         reset = 1'b1;
  reg  [31:0] wl [0:2];
  reg  [31:0] wh [0:2];
  reg  [31:0] pa, c, q;
  reg  [15:0] m, bm, se;
  reg  [1:0]  ps, sk, smc;
  reg         pv, sv, snp, pcr, pwt, edf, edn, dcf, dcn, smv, oir, sir, ok, fe, ne;
  wire        cfg_req, cfg_wr, cfg_ack, pdv, pcl, sfw, sur, omv, fmv, oio, fio;
  wire [11:0] cfg_addr;
  wire [3:0]  cfg_be;
  wire [31:0] cfg_wdata, cfg_rdata;
  wire [1:0]  omc, fmc;
  wire [15:0] cmd, sts;
  integer     fail_count = 0, cmp_count = 0, i, j;

  bhc_cmd_regs #(.ADDR_W(32)) bhc_cmd_regs_i (.core_clk(core_clk), .reset(reset),
    .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .io_window_low(wl[0]), .io_window_high(wh[0]), .mem_window_low(wl[1]),
    .mem_window_high(wh[1]), .prefetch_window_low(wl[2]), .prefetch_window_high(wh[2]),
    .pri_req_valid(pv), .pri_req_space(ps), .pri_req_addr(pa), .pri_dec_valid(pdv),
    .pri_claim(pcl), .sec_req_valid(sv), .sec_req_kind(sk), .sec_req_nonposted(snp),
    .sec_fwd(sfw), .sec_ur(sur), .poison_cpl_rx(pcr), .poison_wr_tx(pwt),
    .err_detect_fatal(edf), .err_detect_nonfatal(edn), .device_control_fatal_en(dcf),
    .device_control_nonfatal_en(dcn), .own_msg_valid(omv), .own_msg_code(omc),
    .sec_msg_valid(smv), .sec_msg_code(smc), .fwd_msg_valid(fmv), .fwd_msg_code(fmc),
    .own_irq_req(oir), .sec_irq_in(sir), .own_irq_out(oio), .fwd_irq_out(fio),
    .command_out(cmd), .status_out(sts));
  bhc_cfg_host bhc_cfg_host_i (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata));

  initial forever #4 core_clk = ~core_clk;

  task close_out;
    begin
      if (fail_count == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("unexpected %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // One access through the host; a missing ack ends the run
  task cfg(input w, input [11:0] a, input [3:0] b, input [31:0] d, input [31:0] e);
    begin
      bhc_cfg_host_i.access(w, a, b, d, q, ok);
      chk("cfg_ack", 32'h1, {31'h0, ok});
      if (!ok)
        close_out;
      else if (!w)
        chk("cfg_rdata", e, q);
    end
  endtask
  function hit(input [31:0] a, input [31:0] lo, input [31:0] hi);
    hit = (a >= lo) && (a <= hi);
  endfunction
  function claim_exp(input [15:0] cm, input [1:0] sp, input [31:0] a);
    claim_exp = (sp == `BHC_SPACE_IO) ? cm[0] && hit(a, wl[0], wh[0])
              : cm[1] && (hit(a, wl[1], wh[1]) || hit(a, wl[2], wh[2]));
  endfunction

  // Fixed corners first, then random command and traffic mixes
  initial begin
    {pv, sv, snp, pcr, pwt, edf, edn, dcf, dcn, smv, oir, sir} = 12'h000;
    {ps, sk, smc, pa} = 38'h0;
    for (j = 0; j < 3; j = j + 1) begin
      wl[j] = 32'h0;
      wh[j] = 32'h0;
    end
    c = $urandom(32'h0326);
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    @(posedge core_clk);
    #1 chk("command_out", 32'h0, {16'h0, cmd});
    cfg(1'b0, `BHC_OFF_CMD, 4'hf, 32'h0, 32'h0);
    cfg(1'b1, `BHC_OFF_ID, 4'hf, 32'hffffffff, 32'h0);
    cfg(1'b0, `BHC_OFF_ID, 4'hf, 32'h0, {`BHC_PART_CODE, `BHC_VENDOR_CODE});
    cfg(1'b0, 12'h0f0, 4'hf, 32'h0, 32'h0);
    cfg(1'b1, `BHC_OFF_CMD, 4'h3, 32'hffffffff, 32'h0);
    cfg(1'b0, `BHC_OFF_CMD, 4'hf, 32'h0, {16'h0, `BHC_CMD_WR_MASK});
    pcr = 1'b1;
    edf = 1'b1;
    @(posedge core_clk);
    #1 {pcr, edf} = 2'h0;
    cfg(1'b0, `BHC_OFF_CMD, 4'hf, 32'h0, {16'h4100, `BHC_CMD_WR_MASK});
    cfg(1'b1, `BHC_OFF_CMD, 4'hc, 32'h0, 32'h0);
    cfg(1'b0, `BHC_OFF_CMD, 4'hf, 32'h0, {16'h4100, `BHC_CMD_WR_MASK});
    cfg(1'b1, `BHC_OFF_CMD, 4'hf, 32'h41000000, 32'h0);
    pwt = 1'b1;
    @(posedge core_clk);
    #1 pwt = 1'b0;
    cfg(1'b0, `BHC_OFF_CMD, 4'hf, 32'h0, 32'h0);
    m = 16'h0000;
    se = 16'h0000;
    for (i = 0; i < 300; i = i + 1) begin
      c = $urandom;
      // Random byte enables: command bytes merge, status bytes clear on one
      bm = {{8{c[17]}}, {8{c[16]}}};
      m = (m & ~bm) | (c[15:0] & bm & `BHC_CMD_WR_MASK);
      cfg(1'b1, `BHC_OFF_CMD, {c[19:18], c[17:16]}, c, 32'h0);
      bm = {{8{c[19]}}, {8{c[18]}}};
      se = se & ~(c[31:16] & bm);
      for (j = 0; j < 3; j = j + 1) begin
        wl[j] = $urandom & 32'hfff00000;
        wh[j] = wl[j] | 32'h000fffff;
      end
      j = $urandom % 3;
      case ($urandom % 4)
        0: pa = wl[j];
        1: pa = wh[j];
        2: pa = wh[j] + 32'h1;
        default: pa = wl[j] - 32'h1;
      endcase
      c = $urandom;
      {ps, sk, smc, snp, edf, edn, dcf, dcn, oir, sir} = c[13:0];
      if (smc == 2'h2)
        smc = `BHC_MSG_FATAL;
      {pcr, pwt} = c[15:14];
      {pv, sv, smv} = 3'h7;
      fe = edf && (m[8] || dcf);
      ne = edn && (m[8] || dcn);
      se = se | {1'b0, m[8] && (fe || ne || smc != `BHC_MSG_COR), 5'h00,
                 m[6] && (pcr || pwt), 8'h00};
      @(posedge core_clk);
      #1 {pv, sv, smv, edf, edn, pcr, pwt} = 7'h00;
      chk("pri_claim", claim_exp(m, ps, pa), pcl);
      chk("pri_dec_valid", 32'h1, pdv);
      chk("sec_fwd", sk >= `BHC_KIND_OTHER || m[2], sfw);
      chk("sec_ur", sk < `BHC_KIND_OTHER && !m[2] && snp, sur);
      chk("fwd_msg_valid", smc == `BHC_MSG_COR || m[8], fmv);
      chk("fwd_msg_code", smc, fmc);
      chk("own_msg_valid", fe || ne, omv);
      if (fe || ne)
        chk("own_msg_code", fe ? `BHC_MSG_FATAL : `BHC_MSG_NONFATAL, omc);
      chk("own_irq_out", oir && !m[10], oio);
      chk("fwd_irq_out", sir, fio);
      chk("command_out", m, cmd);
      chk("status_out", se, sts);
    end
    // Mid-run reset must clear every writable bit and both flags
    {oir, sir, dcf, dcn, snp} = 5'h00;
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    cfg(1'b0, `BHC_OFF_CMD, 4'hf, 32'h0, 32'h0);
    close_out;
  end
endmodule
